/* File: sonet_oh_pkg.sv */
// Shared constants and types for the overhead datapath top and its add lanes
package sonet_oh_pkg;
	localparam int LANES = 16;
	localparam int SYNC_STAGES = 3;
	localparam int GROUPS = 4;
	localparam int GROUP_LANES = 4;
	localparam logic [15:0] FRAME_WORD = 16'hF628;
	localparam logic [6:0] SCRAMBLER_SEED = 7'h7F;
	// Frame geometry in byte columns; each column is eight rising edges of the line clock
	localparam logic [6:0] FRAME_COLS = 7'd90;
	localparam logic [6:0] OH_COLS = 7'd3;
	localparam logic [3:0] ROWS = 4'd9;
	localparam logic [3:0] PTR_ROW = 4'd3;
	localparam logic [6:0] H1_COL = 7'd0;
	localparam logic [6:0] H2_COL = 7'd1;
	localparam logic [6:0] COL_AFTER_FRAMING = 7'd2;
	localparam logic [2:0] LAST_BIT = 3'd7;
	// Pin vector positions after the input synchronisers
	localparam int PIN_RX_CLK = 0;
	localparam int PIN_TX_CLK = 1;
	localparam int PIN_DROP_CLK = 2;
	localparam int PIN_TX_FS = 3;
	localparam int PIN_RATE = 4;
	localparam int PIN_BYPASS = 5;
	localparam int PIN_HOST = 6;
	localparam int PIN_RX_DATA = 7;
	localparam int PIN_COUNT = 23;
	typedef enum logic [1:0] {
		LINE_HUNT = 2'b00,
		LINE_LOCKED = 2'b01
	} line_state_t;
endpackage

/* File: add_lane_recover.sv */
// One add stream: edge recovery, framing, byte alignment, descrambling and a small buffer
`timescale 1ns/1ps
module add_lane_recover #(
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Serial add stream and its recovered clock
	input wire logic i_add_bit,
	input wire logic i_add_clock,
	// Read side
	input wire logic i_pop,
	output logic [7:0] o_byte,
	output logic o_ready,
	output logic o_locked
);
	import sonet_oh_pkg::*;
	localparam int AW = $clog2(DEPTH);
	logic [SYNC_STAGES-1:0] clk_sync;
	logic [SYNC_STAGES-1:0] bit_sync;
	logic clk_level, next_clk_level, bit_level, next_bit_level;
	logic [15:0] shift, next_shift;
	logic [7:0] desc, next_desc;
	logic locked, next_locked;
	logic [2:0] bit_count, next_bit_count;
	logic [6:0] scr, next_scr;
	logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [7:0] mem [DEPTH];
	logic [7:0] out_byte, next_out;
	logic clk_rise, word_done, full, empty;

	always_comb begin
		next_clk_level = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_level;
		next_bit_level = (bit_sync[1] == bit_sync[2]) ? bit_sync[2] : bit_level;
		clk_rise = next_clk_level & ~clk_level;
		next_shift = shift;
		next_desc = desc;
		next_locked = locked;
		next_bit_count = bit_count;
		next_scr = scr;
		word_done = 1'b0;
		if (clk_rise) begin
			next_shift = {shift[14:0], bit_level};
			if (next_shift == FRAME_WORD) begin
				next_locked = 1'b1;
				next_bit_count = '0;
				next_scr = SCRAMBLER_SEED;
			end else if (locked) begin
				next_desc = {desc[6:0], bit_level ^ scr[6]};
				next_scr = {scr[5:0], scr[6] ^ scr[5]};
				next_bit_count = bit_count + 3'd1;
				word_done = (bit_count == LAST_BIT);
			end
		end
		full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
		empty = (wr_ptr == rd_ptr);
		next_wr_ptr = wr_ptr + {{AW{1'b0}}, word_done & ~full};
		next_rd_ptr = rd_ptr + {{AW{1'b0}}, i_pop & ~empty};
		next_out = (i_pop && !empty) ? mem[rd_ptr[AW-1:0]] : out_byte;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			clk_sync <= '0;
			bit_sync <= '0;
			clk_level <= 1'b0;
			bit_level <= 1'b0;
			shift <= '0;
			desc <= '0;
			locked <= 1'b0;
			bit_count <= '0;
			scr <= SCRAMBLER_SEED;
			wr_ptr <= '0;
			rd_ptr <= '0;
			out_byte <= '0;
		end else begin
			clk_sync <= {clk_sync[1:0], i_add_clock};
			bit_sync <= {bit_sync[1:0], i_add_bit};
			clk_level <= next_clk_level;
			bit_level <= next_bit_level;
			shift <= next_shift;
			desc <= next_desc;
			locked <= next_locked;
			bit_count <= next_bit_count;
			scr <= next_scr;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			out_byte <= next_out;
		end
	end

	always_ff @(posedge i_clock) begin
		if (word_done && !full) begin
			mem[wr_ptr[AW-1:0]] <= next_desc;
		end
	end

	assign o_byte = out_byte;
	assign o_ready = ~empty;
	assign o_locked = locked;

	lane_write_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		word_done && !full && !(i_pop && !empty) |=>
		(AW+1)'(wr_ptr - rd_ptr) == (AW+1)'($past(wr_ptr - rd_ptr) + 1))
		else $error("add lane byte was not buffered");
endmodule

/* File: sonet_overhead_datapath_top.sv */
// Overhead terminator datapath top: mode straps, add, transmit, receive and drop paths
`timescale 1ns/1ps
module sonet_overhead_datapath_top #(
	parameter int DROP_DEPTH = 4,
	parameter int ADD_DEPTH = 4
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Mode straps and resulting modes
	input wire logic i_rate_select_strap,
	input wire logic i_drop_retiming_bypass,
	input wire logic i_host_port_sync_select,
	output logic o_quad_sts48_mode,
	output logic o_bypass_active,
	output logic o_host_port_sync,
	// Add side streams
	input wire logic [sonet_oh_pkg::LANES-1:0] i_add_data,
	input wire logic [sonet_oh_pkg::LANES-1:0] i_add_clock,
	output logic [sonet_oh_pkg::LANES-1:0] o_add_locked,
	// Transmit line
	input wire logic i_tx_clock,
	input wire logic i_tx_frame_sync,
	input wire logic i_tx_scramble_enable,
	input wire logic i_tx_oh_source_serial,
	input wire logic [sonet_oh_pkg::LANES-1:0] i_tx_oh_serial_word,
	input wire logic [sonet_oh_pkg::LANES-1:0] i_tx_oh_config_word,
	output logic [sonet_oh_pkg::LANES-1:0] o_tx_line_data,
	output logic o_tx_line_valid,
	// Receive line
	input wire logic i_rx_line_clock,
	input wire logic [sonet_oh_pkg::LANES-1:0] i_rx_line_data,
	input wire logic i_rx_descramble_enable,
	input wire logic i_rx_oh_serial_enable,
	input wire logic i_rx_poh_monitor,
	output logic o_rx_in_frame,
	output logic [sonet_oh_pkg::LANES-1:0] o_rx_oh_data,
	output logic o_rx_oh_valid,
	output logic [sonet_oh_pkg::LANES-1:0] o_rx_oh_held,
	output logic [9:0] o_rx_pointer,
	output logic o_rx_spe_start,
	output logic [sonet_oh_pkg::LANES-1:0] o_rx_poh_word,
	output logic o_rx_path_alarm,
	// Drop side
	input wire logic i_drop_clock,
	output logic [sonet_oh_pkg::LANES-1:0] o_drop_data,
	output logic o_drop_valid,
	output logic o_drop_spe,
	output logic o_drop_adjust
);
	import sonet_oh_pkg::*;
	localparam int DAW = $clog2(DROP_DEPTH);
	logic [PIN_COUNT-1:0] pin_s1, pin_s2, pin_s3, pin_level, next_pin_level;
	logic [PIN_COUNT-1:0] pin_raw;
	logic [1:0] settle, next_settle;
	logic straps_taken, next_straps_taken;
	logic quad, next_quad, bypass, next_bypass, host_sync, next_host_sync;
	logic rx_rise, tx_rise, drop_rise, fs_rise;
	// Add lanes
	logic [LANES-1:0] lane_ready, pop;
	logic [7:0] lane_byte [LANES];
	// Transmit state
	logic fs_pend, next_fs_pend;
	logic [2:0] tx_bit, next_tx_bit;
	logic [6:0] tx_col, next_tx_col;
	logic [3:0] tx_row, next_tx_row;
	logic [6:0] tx_scr, next_tx_scr;
	logic [LANES-1:0] tx_word, next_tx_word, add_bits;
	logic tx_valid, next_tx_valid, tx_ptr_pos, tx_oh_pos, tx_frm_pos;
	// Receive state
	line_state_t rx_state, next_rx_state;
	logic [GROUPS-1:0][15:0] rx_shift, next_rx_shift;
	logic [GROUPS-1:0] lead_match;
	logic frame_match;
	logic [2:0] rx_bit, next_rx_bit;
	logic [6:0] rx_col, next_rx_col;
	logic [3:0] rx_row, next_rx_row;
	logic [6:0] rx_scr, next_rx_scr;
	logic [LANES-1:0] rx_word, oh_data, next_oh_data, oh_held, next_oh_held;
	logic [LANES-1:0] poh_word, next_poh_word;
	logic oh_valid, next_oh_valid, spe_start, next_spe_start;
	logic rx_ptr_pos, rx_oh_pos, rx_frm_pos, rx_pay;
	logic [15:0] ptr_shift, next_ptr_shift;
	logic [9:0] pointer, next_pointer, pay_idx, next_pay_idx;
	// Drop state
	logic [LANES:0] drop_mem [DROP_DEPTH];
	logic [DAW:0] dwr, next_dwr, drd, next_drd, drop_count;
	logic [LANES-1:0] drop_data, next_drop_data;
	logic drop_valid, next_drop_valid, drop_spe, next_drop_spe, adjust, next_adjust;
	logic drop_write;

	assign pin_raw = {i_rx_line_data, i_host_port_sync_select, i_drop_retiming_bypass,
		i_rate_select_strap, i_tx_frame_sync, i_drop_clock, i_tx_clock, i_rx_line_clock};

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : gen_lane
			add_lane_recover #(.DEPTH(ADD_DEPTH)) u_lane (
				.i_clock(i_clock),
				.i_nrst(i_nrst),
				.i_add_bit(i_add_data[g]),
				.i_add_clock(i_add_clock[g]),
				.i_pop(pop[g]),
				.o_byte(lane_byte[g]),
				.o_ready(lane_ready[g]),
				.o_locked(o_add_locked[g])
			);
			assign add_bits[g] = lane_byte[g][LAST_BIT - tx_bit];
		end
	endgenerate

	// Pins, strap capture
	always_comb begin
		next_pin_level = pin_level;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (pin_s2[i] == pin_s3[i]) next_pin_level[i] = pin_s3[i];
		end
		rx_rise = next_pin_level[PIN_RX_CLK] & ~pin_level[PIN_RX_CLK];
		tx_rise = next_pin_level[PIN_TX_CLK] & ~pin_level[PIN_TX_CLK];
		drop_rise = next_pin_level[PIN_DROP_CLK] & ~pin_level[PIN_DROP_CLK];
		fs_rise = next_pin_level[PIN_TX_FS] & ~pin_level[PIN_TX_FS];
		next_settle = (settle == 2'(SYNC_STAGES)) ? settle : settle + 2'd1;
		next_straps_taken = straps_taken | (settle == 2'(SYNC_STAGES));
		next_quad = quad;
		next_bypass = bypass;
		next_host_sync = host_sync;
		// Straps are sampled once; later changes are ignored on purpose
		if (!straps_taken && settle == 2'(SYNC_STAGES)) begin
			// Filtered level lands on this same edge, so take the incoming value
			// rate, bypass and host port sync modes
			next_quad = next_pin_level[PIN_RATE];
			next_bypass = next_pin_level[PIN_BYPASS];
			next_host_sync = next_pin_level[PIN_HOST];
		end
	end

	// Transmit path
	always_comb begin
		tx_frm_pos = (tx_row == '0) && (tx_col < COL_AFTER_FRAMING);
		tx_ptr_pos = (tx_row == PTR_ROW) && (tx_col == H1_COL || tx_col == H2_COL);
		tx_oh_pos = (tx_col < OH_COLS);
		next_fs_pend = fs_rise | (fs_pend & ~tx_rise);
		next_tx_bit = tx_bit;
		next_tx_col = tx_col;
		next_tx_row = tx_row;
		next_tx_scr = tx_scr;
		next_tx_word = tx_word;
		next_tx_valid = 1'b0;
		pop = '0;
		if (tx_rise) begin
			next_tx_valid = 1'b1;
			// overhead source, pointers from add data
			if (tx_frm_pos) next_tx_word = {LANES{FRAME_WORD[4'(15 - {tx_col[0], tx_bit})]}};
			else if (tx_oh_pos && !tx_ptr_pos)
				next_tx_word = i_tx_oh_source_serial ? i_tx_oh_serial_word : i_tx_oh_config_word;
			else next_tx_word = add_bits;
			// optional scrambling, first row overhead left clear
			if (i_tx_scramble_enable && !(tx_row == '0 && tx_oh_pos))
				next_tx_word = next_tx_word ^ {LANES{tx_scr[6]}};
			next_tx_scr = {tx_scr[5:0], tx_scr[6] ^ tx_scr[5]};
			next_tx_bit = tx_bit + 3'd1;
			if (tx_bit == LAST_BIT) begin
				pop = (&lane_ready) ? '1 : '0;
				next_tx_col = (tx_col == FRAME_COLS - 7'd1) ? '0 : tx_col + 7'd1;
				if (tx_col == FRAME_COLS - 7'd1)
					next_tx_row = (tx_row == ROWS - 4'd1) ? '0 : tx_row + 4'd1;
			end
			if (fs_pend) begin
				next_tx_bit = '0;
				next_tx_col = '0;
				next_tx_row = '0;
				next_tx_scr = SCRAMBLER_SEED;
			end
		end
	end

	// Receive path
	always_comb begin
		rx_word = pin_level[PIN_RX_DATA +: LANES];
		next_rx_shift = rx_shift;
		for (int k = 0; k < GROUPS; k++) begin
			if (rx_rise) next_rx_shift[k] = {rx_shift[k][14:0], rx_word[k * GROUP_LANES]};
			lead_match[k] = (next_rx_shift[k] == FRAME_WORD);
		end
		// per channel framing; quad mode needs every channel in frame
		frame_match = rx_rise && (quad ? &lead_match : lead_match[0]);
		rx_frm_pos = (rx_row == '0) && (rx_col < COL_AFTER_FRAMING);
		rx_ptr_pos = (rx_row == PTR_ROW) && (rx_col == H1_COL || rx_col == H2_COL);
		rx_oh_pos = (rx_col < OH_COLS) && !rx_frm_pos && !rx_ptr_pos;
		rx_pay = (rx_state == LINE_LOCKED) && rx_rise && (rx_col >= OH_COLS);
		if (i_rx_descramble_enable && !(rx_row == '0 && rx_col < OH_COLS))
			rx_word = rx_word ^ {LANES{rx_scr[6]}};
		next_rx_state = rx_state;
		next_rx_bit = rx_bit;
		next_rx_col = rx_col;
		next_rx_row = rx_row;
		next_rx_scr = rx_scr;
		next_oh_data = oh_data;
		next_oh_held = oh_held;
		next_oh_valid = 1'b0;
		next_ptr_shift = ptr_shift;
		next_pointer = pointer;
		next_pay_idx = pay_idx;
		next_spe_start = 1'b0;
		next_poh_word = poh_word;
		case (rx_state)
			LINE_HUNT: begin
				if (frame_match) next_rx_state = LINE_LOCKED;
			end
			LINE_LOCKED: begin
				if (rx_rise) begin
					if (rx_oh_pos && i_rx_oh_serial_enable) begin
						next_oh_data = rx_word;
						next_oh_valid = 1'b1;
					end else if (rx_oh_pos) begin
						next_oh_held = rx_word;
					end
					if (rx_ptr_pos) next_ptr_shift = {ptr_shift[14:0], rx_word[0]};
					if (rx_ptr_pos && rx_col == H2_COL && rx_bit == LAST_BIT)
						next_pointer = next_ptr_shift[9:0];
					if (rx_pay && rx_bit == '0 && pay_idx == pointer) begin
						next_spe_start = 1'b1;
						next_poh_word = rx_word;
					end
					if (rx_pay && rx_bit == LAST_BIT) next_pay_idx = pay_idx + 10'd1;
					next_rx_scr = {rx_scr[5:0], rx_scr[6] ^ rx_scr[5]};
					next_rx_bit = rx_bit + 3'd1;
					if (rx_bit == LAST_BIT) begin
						next_rx_col = (rx_col == FRAME_COLS - 7'd1) ? '0 : rx_col + 7'd1;
						if (rx_col == FRAME_COLS - 7'd1)
							next_rx_row = (rx_row == ROWS - 4'd1) ? '0 : rx_row + 4'd1;
					end
				end
			end
			default: next_rx_state = LINE_HUNT;
		endcase
		if (frame_match) begin
			next_rx_bit = '0;
			next_rx_col = COL_AFTER_FRAMING;
			next_rx_row = '0;
			next_rx_scr = SCRAMBLER_SEED;
			next_pay_idx = '0;
		end
	end

	// Drop aligner
	always_comb begin
		drop_count = dwr - drd;
		drop_write = rx_pay && !bypass;
		next_dwr = dwr;
		next_drd = drd;
		next_drop_data = drop_data;
		next_drop_valid = 1'b0;
		next_drop_spe = 1'b0;
		next_adjust = 1'b0;
		if (bypass) begin
			// no store, receive timing drives the drop side
			if (rx_pay) begin
				next_drop_data = rx_word;
				next_drop_valid = 1'b1;
				next_drop_spe = next_spe_start;
			end
		end else begin
			// elastic store with adjustment on slip
			if (drop_write && drop_count == (DAW+1)'(DROP_DEPTH)) next_adjust = 1'b1;
			else if (drop_write) next_dwr = dwr + {{DAW{1'b0}}, 1'b1};
			if (drop_rise && drop_count == '0) next_adjust = 1'b1;
			else if (drop_rise) begin
				next_drop_data = drop_mem[drd[DAW-1:0]][LANES-1:0];
				next_drop_spe = drop_mem[drd[DAW-1:0]][LANES];
				next_drop_valid = 1'b1;
				next_drd = drd + {{DAW{1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (drop_write && drop_count != (DAW+1)'(DROP_DEPTH))
			drop_mem[dwr[DAW-1:0]] <= {next_spe_start, rx_word};
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			{pin_s1, pin_s2, pin_s3, pin_level} <= '0;
			settle <= '0;
			{straps_taken, quad, bypass, host_sync} <= '0;
			{fs_pend, tx_valid, oh_valid, spe_start} <= '0;
			{tx_bit, tx_col, tx_row, rx_bit, rx_col, rx_row} <= '0;
			tx_scr <= SCRAMBLER_SEED;
			rx_scr <= SCRAMBLER_SEED;
			{tx_word, oh_data, oh_held, poh_word, drop_data} <= '0;
			rx_state <= LINE_HUNT;
			rx_shift <= '0;
			{ptr_shift, pointer, pay_idx} <= '0;
			{dwr, drd, drop_valid, drop_spe, adjust} <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_level <= next_pin_level;
			settle <= next_settle;
			straps_taken <= next_straps_taken;
			quad <= next_quad;
			bypass <= next_bypass;
			host_sync <= next_host_sync;
			fs_pend <= next_fs_pend;
			tx_bit <= next_tx_bit;
			tx_col <= next_tx_col;
			tx_row <= next_tx_row;
			tx_scr <= next_tx_scr;
			tx_word <= next_tx_word;
			tx_valid <= next_tx_valid;
			rx_state <= next_rx_state;
			rx_shift <= next_rx_shift;
			rx_bit <= next_rx_bit;
			rx_col <= next_rx_col;
			rx_row <= next_rx_row;
			rx_scr <= next_rx_scr;
			oh_data <= next_oh_data;
			oh_held <= next_oh_held;
			oh_valid <= next_oh_valid;
			ptr_shift <= next_ptr_shift;
			pointer <= next_pointer;
			pay_idx <= next_pay_idx;
			spe_start <= next_spe_start;
			poh_word <= next_poh_word;
			dwr <= next_dwr;
			drd <= next_drd;
			drop_data <= next_drop_data;
			drop_valid <= next_drop_valid;
			drop_spe <= next_drop_spe;
			adjust <= next_adjust;
		end
	end

	assign o_quad_sts48_mode = quad;
	assign o_bypass_active = bypass;
	assign o_host_port_sync = host_sync;
	assign o_tx_line_data = tx_word;
	assign o_tx_line_valid = tx_valid;
	assign o_rx_in_frame = (rx_state == LINE_LOCKED);
	assign o_rx_oh_data = oh_data;
	assign o_rx_oh_valid = oh_valid;
	assign o_rx_oh_held = oh_held;
	assign o_rx_pointer = pointer;
	assign o_rx_spe_start = spe_start;
	assign o_rx_poh_word = poh_word;
	// unequipped path flagged only while monitoring
	assign o_rx_path_alarm = i_rx_poh_monitor && (rx_state == LINE_LOCKED) && (poh_word == '0);
	assign o_drop_data = drop_data;
	assign o_drop_valid = drop_valid;
	assign o_drop_spe = drop_spe;
	assign o_drop_adjust = adjust;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	sequence tx_edge_at_ptr;
		tx_rise && tx_ptr_pos && !tx_frm_pos && !i_tx_scramble_enable;
	endsequence
	rate_mode_a: assert property ($rose(straps_taken) |-> o_quad_sts48_mode == pin_level[PIN_RATE])
		else $error("rate mode does not follow strap");
	bypass_store_a: assert property (o_bypass_active |-> drop_count == '0)
		else $error("elastic store used in bypass");
	bypass_timing_a: assert property (o_bypass_active && o_drop_valid |-> $past(rx_pay))
		else $error("bypass drop not on receive timing");
	host_mode_a: assert property ($rose(straps_taken) |-> o_host_port_sync == pin_level[PIN_HOST])
		else $error("host port mode does not follow strap");
	frame_restart_a: assert property (tx_rise && fs_pend |=> tx_col == '0 && tx_row == '0 && tx_bit == '0)
		else $error("frame sync did not restart transmit frame");
	ptr_from_add_a: assert property (tx_edge_at_ptr |=> o_tx_line_data == $past(add_bits))
		else $error("pointer bytes not taken from add data");
	oh_serial_a: assert property (rx_rise && rx_state == LINE_LOCKED && rx_oh_pos && i_rx_oh_serial_enable |=> o_rx_oh_valid)
		else $error("receive overhead not presented serially");
	spe_start_a: assert property (o_rx_spe_start |-> $past(pay_idx) == o_rx_pointer)
		else $error("envelope start not at pointer");
	drop_stuff_a: assert property (!bypass && drop_rise && drop_count == '0 |=> o_drop_adjust && !o_drop_valid)
		else $error("empty store did not adjust");
	frame_lock_a: assert property (frame_match |=> o_rx_in_frame && rx_col == COL_AFTER_FRAMING)
		else $error("framing pattern did not align receive");
endmodule

/* File: sonet_add_source.sv */
// Add-side source: sixteen serial streams, each with its own phase-shifted clock
`timescale 1ns/1ps
module sonet_add_source (
	// Start of the add frame
	input wire logic i_enable,
	// Serial add streams and clocks
	output logic [15:0] o_add_data,
	output logic [15:0] o_add_clock
);
	import sonet_oh_pkg::*;
	for (genvar g = 0; g < 16; g++) begin : lane
		initial begin
			o_add_clock[g] = 1'b0;
			o_add_data[g] = 1'b0;
			wait (i_enable === 1'b1);
			#(g * 5);
			for (int b = 0; b < 48; b++) begin
				o_add_data[g] = (b < 16) ? FRAME_WORD[15 - b] : b[0];
				#40 o_add_clock[g] = 1'b1;
				#40 o_add_clock[g] = 1'b0;
			end
			// Clock stands still; line no longer holds the last bit
			o_add_data[g] = ~o_add_data[g];
		end
	end
endmodule

/* File: sonet_overhead_datapath_top_tb_top.sv */
// Self-checking bench for the overhead datapath top
`timescale 1ns/1ps
module sonet_overhead_datapath_top_tb_top;
	import sonet_oh_pkg::*;
	logic i_clock = 0, i_nrst = 0, i_rate_select_strap = 0, i_drop_retiming_bypass = 0;
	logic i_host_port_sync_select = 0, i_tx_clock = 0, i_tx_frame_sync = 0;
	logic i_tx_scramble_enable = 1, i_tx_oh_source_serial = 0, i_rx_line_clock = 0;
	logic i_rx_descramble_enable = 0, i_rx_oh_serial_enable = 0, i_rx_poh_monitor = 0;
	logic i_drop_clock = 0, drop_run = 0, add_en = 0;
	logic [15:0] i_tx_oh_serial_word = 16'h0000, i_tx_oh_config_word = 16'hFFFF;
	logic [15:0] i_rx_line_data = 16'h0000, i_add_data, i_add_clock, o_add_locked;
	logic [15:0] o_tx_line_data, o_rx_oh_data, o_rx_oh_held, o_rx_poh_word, o_drop_data;
	logic [9:0] o_rx_pointer;
	logic [3:0] rx_bit = 4'h0;
	logic o_quad_sts48_mode, o_bypass_active, o_host_port_sync, o_tx_line_valid;
	logic o_rx_in_frame, o_rx_oh_valid, o_rx_spe_start, o_rx_path_alarm;
	logic o_drop_valid, o_drop_spe, o_drop_adjust;
	int fails = 0, checked = 0;
	// Fourth add byte: alternating data 8'h55 under the fourth descrambler byte 8'h51
	localparam logic [7:0] LAST_ADD_BYTE = 8'h04;
	always #2.5 i_clock = ~i_clock;
	always #40 i_tx_clock = ~i_tx_clock;
	always #40 i_rx_line_clock = ~i_rx_line_clock;
	always #40 i_drop_clock = drop_run ? ~i_drop_clock : 1'b0;
	always @(negedge i_rx_line_clock) begin
		i_rx_line_data <= {16{FRAME_WORD[4'hF - rx_bit]}};
		rx_bit <= rx_bit + 4'h1;
	end
	sonet_add_source u_src (.i_enable(add_en), .o_add_data(i_add_data), .o_add_clock(i_add_clock));
	sonet_overhead_datapath_top u_dut (.i_clock, .i_nrst, .i_rate_select_strap,
		.i_drop_retiming_bypass, .i_host_port_sync_select, .o_quad_sts48_mode,
		.o_bypass_active, .o_host_port_sync, .i_add_data, .i_add_clock, .o_add_locked,
		.i_tx_clock, .i_tx_frame_sync, .i_tx_scramble_enable, .i_tx_oh_source_serial,
		.i_tx_oh_serial_word, .i_tx_oh_config_word, .o_tx_line_data, .o_tx_line_valid,
		.i_rx_line_clock, .i_rx_line_data, .i_rx_descramble_enable, .i_rx_oh_serial_enable,
		.i_rx_poh_monitor, .o_rx_in_frame, .o_rx_oh_data, .o_rx_oh_valid, .o_rx_oh_held,
		.o_rx_pointer, .o_rx_spe_start, .o_rx_poh_word, .o_rx_path_alarm, .i_drop_clock,
		.o_drop_data, .o_drop_valid, .o_drop_spe, .o_drop_adjust);
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: pick = o_rx_in_frame;
			1: pick = o_drop_valid;
			2: pick = &o_add_locked;
			4: pick = o_rx_oh_valid;
			5: pick = o_rx_spe_start;
			6: pick = o_drop_adjust;
			default: pick = o_tx_line_valid;
		endcase
	endfunction
	// Bounded wait; running out ends the run
	task automatic wait_sig(input int sel, input int lim);
		int n;
		n = 0;
		while (pick(sel) !== 1'b1 && n < lim) begin
			@(negedge i_clock);
			n++;
		end
		checked++;
		if (n >= lim) begin
			fails++;
			$display("mismatch wait %0d expected 1 seen 0", sel);
			print_verdict();
		end
	endtask
	// Straps held stable across reset release and left alone afterwards
	task automatic do_reset(input logic rate, input logic byp, input logic host);
		@(negedge i_clock);
		i_nrst = 0;
		i_rate_select_strap = rate;
		i_drop_retiming_bypass = byp;
		i_host_port_sync_select = host;
		repeat (10) @(negedge i_clock);
		i_nrst = 1;
		repeat (8) @(negedge i_clock);
		cmp("modes", {13'h0000, rate, byp, host},
			{13'h0000, o_quad_sts48_mode, o_bypass_active, o_host_port_sync});
	endtask
	// Bypass: drop words follow receive timing with the drop clock stopped
	task automatic t_rx_bypass();
		wait_sig(0, 2000);
		wait_sig(1, 4000);
		cmp("bypass drop data", {16{FRAME_WORD[7]}}, o_drop_data);
		cmp("bypass drop spe", 16'h0001, {15'h0000, o_drop_spe});
		cmp("oh held", {16{FRAME_WORD[8]}}, o_rx_oh_held);
	endtask
	// Retimed drop path delivers words on the drop clock
	task automatic t_drop();
		drop_run = 1;
		i_rx_oh_serial_enable = 1;
		i_rx_poh_monitor = 1;
		// Empty store with the drop clock running must stuff
		wait_sig(6, 100);
		wait_sig(0, 2000);
		wait_sig(4, 100);
		cmp("oh serial data", {16{FRAME_WORD[15]}}, o_rx_oh_data);
		wait_sig(5, 400);
		cmp("poh word", {16{FRAME_WORD[7]}}, o_rx_poh_word);
		cmp("path alarm", {15'h0000, ~FRAME_WORD[7]}, {15'h0000, o_rx_path_alarm});
		// Test frames realign every 16 bits, so no pointer row ever arrives
		cmp("pointer", 16'h0000, {6'h00, o_rx_pointer});
		wait_sig(1, 4000);
		cmp("drop data", {16{FRAME_WORD[7]}}, o_drop_data);
		cmp("drop spe", 16'h0001, {15'h0000, o_drop_spe});
	endtask
	task automatic t_add();
		add_en = 1;
		wait_sig(2, 3000);
	endtask
	// Frame start: framing word unscrambled on every lane, MSB first
	task automatic t_tx();
		i_tx_oh_source_serial = 1;
		@(negedge i_tx_clock);
		i_tx_frame_sync = 1;
		// The edge that applies the restart still carries the old position
		wait_sig(3, 100);
		@(negedge i_clock);
		for (int i = 0; i < 16; i++) begin
			wait_sig(3, 100);
			cmp("tx word", {16{FRAME_WORD[15 - i]}}, o_tx_line_data);
			@(negedge i_clock);
			if (i == 4) begin
				i_tx_frame_sync = 0;
			end
		end
	endtask
	// Row three pointer columns repeat the last add byte of every lane, unscrambled
	task automatic t_tx_ptr();
		int first;
		first = int'(PTR_ROW) * int'(FRAME_COLS) * 8;
		i_tx_scramble_enable = 0;
		for (int k = 16; k < first + 16; k++) begin
			wait_sig(3, 100);
			if (k >= first) begin
				cmp("tx pointer", {16{LAST_ADD_BYTE[7 - (k % 8)]}}, o_tx_line_data);
			end
			@(negedge i_clock);
		end
	endtask
	// this block has no test port; its test reset counts as held low
	initial begin
		do_reset(1'b0, 1'b1, 1'b1);
		t_rx_bypass();
		do_reset(1'b1, 1'b0, 1'b0);
		t_drop();
		t_add();
		t_tx();
		t_tx_ptr();
		print_verdict();
	end
endmodule
